/* hw/phy_basic_control.sv */
`timescale 1ns/10ps
// Function
// - Writing one to bit 15 starts soft reset
// - Other bits ignore writes during reset
// - Writing zero to reset bit does nothing
// - Bit 14 sets and reports loopback
// - Software disable forces speed from bit 13
// - Otherwise bit 13 does not affect speed
// - Bit 13 reads software value; combined separate
// - Pin low disables negotiation in hardware
// - Bit 12 zero disables, one re-enables negotiation
// - Pin disable masks software enable bit
// - Bit 12 reads last written, default one
// - Bit 11 is read-only zero
// - Bit 10 isolates data interface
// - Bit 9 restarts negotiation, reads zero
// - Auxiliary restart acts the same
// - Disabled negotiation duplex is bit OR pin
// - Collision test raises and drops collision
// - Bit 7 enables collision test mode
// - Reserved bits 6 to 0 read zero
module phy_basic_control (
    input wire logic clk,
    input wire logic nrst,
    input wire phy_ctrl_pkg::mgmt_req_s mgmt_req,
    input wire logic aux_restart,
    input wire phy_ctrl_pkg::pins_s pins,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic an_restart_ack,
    output logic [15:0] mgmt_rdata,
    output logic soft_reset,
    output logic loopback,
    output logic isolate,
    output logic speed_100,
    output logic full_duplex,
    output logic autoneg_active,
    output logic an_restart,
    output logic aux_forced_speed,
    output logic col
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    phy_ctrl_pkg::pins_s pins_sync;
    phy_ctrl_pkg::srst_state_e srst_state_reg;
    phy_ctrl_pkg::srst_state_e srst_state_next;
    logic [8:0] srst_cnt_reg;
    logic [8:0] srst_cnt_next;
    logic loopback_bit_reg;
    logic speed_bit_reg;
    logic an_en_bit_reg;
    logic isolate_bit_reg;
    logic restart_bit_reg;
    logic duplex_bit_reg;
    logic col_test_bit_reg;
    logic [15:0] mgmt_rdata_reg;
    logic soft_reset_reg;
    logic loopback_reg;
    logic isolate_reg;
    logic speed_100_reg;
    logic full_duplex_reg;
    logic autoneg_active_reg;
    logic an_restart_reg;
    logic aux_forced_speed_reg;
    logic col_reg;

    // Pack one bit into a control word position
    function automatic logic [15:0] bit_at(input logic b, input int pos);
        logic [15:0] w;
        w = '0;
        w[pos] = b;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    pin_sync u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .pins_in(pins),
        .pins_out(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    wire ctrl_hit = mgmt_req.addr == phy_ctrl_pkg::CTRL_ADDR;
    wire ctrl_wr = mgmt_req.wr && ctrl_hit;
    wire srst_busy = srst_state_reg == phy_ctrl_pkg::SRST_BUSY;
    wire [15:0] wd = mgmt_req.wdata;
    // Only a one starts the reset
    wire srst_start = ctrl_wr && wd[phy_ctrl_pkg::RESET_BIT] && !srst_busy;
    // Field writes are dropped while resetting
    wire field_wr = ctrl_wr && !srst_busy && !srst_start;
    wire srst_done = srst_busy && srst_cnt_reg == phy_ctrl_pkg::SRST_LAST;

    ////////////////////////////////////////////////////////////////////////
    // Effective operating mode
    wire an_hw_en = pins_sync.autoneg_enable_pin;
    wire an_on = an_hw_en && an_en_bit_reg;
    // Software speed bit whenever the pin enables negotiation, else pin speed
    wire forced_speed = an_hw_en ? speed_bit_reg
                                 : pins_sync.forced_speed_pin;
    wire speed_eff = an_on ? an_speed_100 : forced_speed;
    wire duplex_eff = an_on ? an_full_duplex
                            : (duplex_bit_reg
                               || pins_sync.full_duplex_pin);
    // Restart from either source, only when negotiating
    wire restart_req = (field_wr && wd[phy_ctrl_pkg::AN_RESTART_BIT])
                       || (aux_restart && !srst_busy);

    ////////////////////////////////////////////////////////////////////////
    // Read value: reserved and power-down bits are zero
    wire [15:0] ctrl_rd_val =
        bit_at(srst_busy, phy_ctrl_pkg::RESET_BIT)
        | bit_at(loopback_bit_reg, phy_ctrl_pkg::LOOPBACK_BIT)
        | bit_at(speed_bit_reg, phy_ctrl_pkg::SPEED_BIT)
        | bit_at(an_en_bit_reg, phy_ctrl_pkg::AN_EN_BIT)
        | bit_at(isolate_bit_reg, phy_ctrl_pkg::ISOLATE_BIT)
        | bit_at(duplex_bit_reg, phy_ctrl_pkg::DUPLEX_BIT)
        | bit_at(col_test_bit_reg, phy_ctrl_pkg::COL_TEST_BIT);
    wire [15:0] rdata_next = (mgmt_req.rd && ctrl_hit) ? ctrl_rd_val
                                                       : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Soft reset sequencer
    always_comb begin
        srst_state_next = srst_state_reg;
        srst_cnt_next = 9'h000;
        unique case (srst_state_reg)
            phy_ctrl_pkg::SRST_IDLE: begin
                if (srst_start) begin
                    srst_state_next = phy_ctrl_pkg::SRST_BUSY;
                end
            end
            phy_ctrl_pkg::SRST_BUSY: begin
                srst_cnt_next = srst_cnt_reg + 9'h001;
                if (srst_done) begin
                    srst_state_next = phy_ctrl_pkg::SRST_IDLE;
                    srst_cnt_next = 9'h000;
                end
            end
            default: begin
                srst_state_next = phy_ctrl_pkg::SRST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            srst_state_reg <= phy_ctrl_pkg::SRST_IDLE;
            srst_cnt_reg <= 9'h000;
        end else begin
            srst_state_reg <= srst_state_next;
            srst_cnt_reg <= srst_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields; soft reset restores defaults
    always_ff @(posedge clk) begin
        if (!nrst || srst_start) begin
            loopback_bit_reg <= 1'b0;
            speed_bit_reg <= 1'b1;
            an_en_bit_reg <= 1'b1;
            isolate_bit_reg <= 1'b0;
            duplex_bit_reg <= 1'b0;
            col_test_bit_reg <= 1'b0;
        end else if (field_wr) begin
            loopback_bit_reg <= wd[phy_ctrl_pkg::LOOPBACK_BIT];
            speed_bit_reg <= wd[phy_ctrl_pkg::SPEED_BIT];
            an_en_bit_reg <= wd[phy_ctrl_pkg::AN_EN_BIT];
            isolate_bit_reg <= wd[phy_ctrl_pkg::ISOLATE_BIT];
            duplex_bit_reg <= wd[phy_ctrl_pkg::DUPLEX_BIT];
            col_test_bit_reg <= wd[phy_ctrl_pkg::COL_TEST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Restart request held until the negotiator accepts it
    always_ff @(posedge clk) begin
        if (!nrst || srst_start) begin
            restart_bit_reg <= 1'b0;
        end else if (restart_req && an_on) begin
            restart_bit_reg <= 1'b1; // Set wins over accept
        end else if (an_restart_ack || !an_on) begin
            restart_bit_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mgmt_rdata_reg <= 16'h0000;
            soft_reset_reg <= 1'b0;
            loopback_reg <= 1'b0;
            isolate_reg <= 1'b0;
            speed_100_reg <= 1'b0;
            full_duplex_reg <= 1'b0;
            autoneg_active_reg <= 1'b0;
            an_restart_reg <= 1'b0;
            aux_forced_speed_reg <= 1'b0;
            col_reg <= 1'b0;
        end else begin
            mgmt_rdata_reg <= rdata_next;
            soft_reset_reg <= srst_state_next == phy_ctrl_pkg::SRST_BUSY;
            loopback_reg <= loopback_bit_reg;
            isolate_reg <= isolate_bit_reg;
            speed_100_reg <= speed_eff;
            full_duplex_reg <= duplex_eff;
            autoneg_active_reg <= an_on;
            // One pulse per accepted request
            an_restart_reg <= restart_req && an_on && !restart_bit_reg;
            aux_forced_speed_reg <= forced_speed;
            // Collision follows transmit enable in test mode
            col_reg <= col_test_bit_reg && pins_sync.tx_en;
        end
    end

    assign mgmt_rdata = mgmt_rdata_reg;
    assign soft_reset = soft_reset_reg;
    assign loopback = loopback_reg;
    assign isolate = isolate_reg;
    assign speed_100 = speed_100_reg;
    assign full_duplex = full_duplex_reg;
    assign autoneg_active = autoneg_active_reg;
    assign an_restart = an_restart_reg;
    assign aux_forced_speed = aux_forced_speed_reg;
    assign col = col_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    localparam int SRST_BOUND = 251;
    localparam int COL_BOUND = 10;

    a_srst_self_clear: assert property (
        srst_start |-> ##[1:SRST_BOUND] (srst_state_reg
                                         == phy_ctrl_pkg::SRST_IDLE))
        else $error("Soft reset did not finish in time");

    a_busy_write_ignored: assert property (
        (ctrl_wr && srst_busy && !srst_done) |=> $stable(isolate_bit_reg)
            && $stable(loopback_bit_reg) && $stable(an_en_bit_reg))
        else $error("Field changed during soft reset");

    a_zero_no_reset: assert property (
        (ctrl_wr && !wd[phy_ctrl_pkg::RESET_BIT] && !srst_busy)
            |=> !srst_busy)
        else $error("Writing zero started a reset");

    a_loopback_follows: assert property (
        field_wr |=> ##1 (loopback
                          == $past(wd[phy_ctrl_pkg::LOOPBACK_BIT], 2)))
        else $error("Loopback output not following write");

    a_forced_speed_sel: assert property (
        (an_hw_en && !an_en_bit_reg) |=> speed_100 == $past(speed_bit_reg))
        else $error("Software forced speed not applied");

    a_hw_disable: assert property (
        !an_hw_en |=> !autoneg_active)
        else $error("Pin did not disable negotiation");

    a_duplex_or: assert property (
        !an_on |=> full_duplex == ($past(duplex_bit_reg)
                                   || $past(pins_sync.full_duplex_pin)))
        else $error("Forced duplex is not bit or pin");

    a_read_reserved: assert property (
        1'b1 |-> mgmt_rdata[6:0] == 7'h00 && !mgmt_rdata[11]
                 && !mgmt_rdata[9])
        else $error("Reserved or self-clear bits read nonzero");

    a_col_drop: assert property (
        (col && !pins_sync.tx_en) |-> ##[1:COL_BOUND] !col)
        else $error("Collision not dropped in time");

    a_restart_gate: assert property (
        an_restart |-> $past(an_on))
        else $error("Restart pulsed while negotiation off");

    a_speed_negotiated: assert property (
        an_on |=> speed_100 == $past(an_speed_100))
        else $error("Negotiated speed not applied");

    a_speed_pin: assert property (
        !an_hw_en |=> speed_100 == $past(pins_sync.forced_speed_pin))
        else $error("Pin forced speed not applied");

    a_aux_speed: assert property (
        an_hw_en |=> aux_forced_speed == $past(speed_bit_reg))
        else $error("Combined forced speed not software bit");

    a_read_fields: assert property (
        (mgmt_req.rd && ctrl_hit) |=> mgmt_rdata[13] == $past(speed_bit_reg)
            && mgmt_rdata[12] == $past(an_en_bit_reg))
        else $error("Speed or enable bit read wrong");

    a_an_bit_write: assert property (
        field_wr |=> an_en_bit_reg == $past(wd[phy_ctrl_pkg::AN_EN_BIT]))
        else $error("Enable bit not written");

    a_sw_masked: assert property (
        (!an_hw_en && field_wr && wd[phy_ctrl_pkg::AN_EN_BIT])
            |=> !autoneg_active)
        else $error("Software enable overrode the pin");

    a_isolate_follows: assert property (
        field_wr |=> ##1 (isolate
                          == $past(wd[phy_ctrl_pkg::ISOLATE_BIT], 2)))
        else $error("Isolate output not following write");

    a_col_test_write: assert property (
        field_wr |=> col_test_bit_reg
                     == $past(wd[phy_ctrl_pkg::COL_TEST_BIT]))
        else $error("Collision test bit not written");

    a_col_rise: assert property (
        (col_test_bit_reg && pins_sync.tx_en) |=> col)
        else $error("Collision not raised in test mode");

    a_restart_once: assert property (
        an_restart |=> !an_restart)
        else $error("Restart pulse longer than one cycle");

    a_restart_clear: assert property (
        (restart_bit_reg && an_restart_ack && !restart_req)
            |=> !restart_bit_reg)
        else $error("Restart request not cleared on accept");

    a_aux_restart: assert property (
        (aux_restart && an_on && !srst_busy && !restart_bit_reg)
            |=> an_restart)
        else $error("Auxiliary restart gave no pulse");

    a_soft_defaults: assert property (
        srst_start |=> an_en_bit_reg && speed_bit_reg
                       && !loopback_bit_reg && !isolate_bit_reg)
        else $error("Soft reset did not restore defaults");

    c_soft_reset: cover property (srst_start ##[1:SRST_BOUND] srst_done);
    c_restart: cover property (an_restart);
    c_col_test: cover property (col ##1 !col);
    c_forced: cover property (an_hw_en && !an_en_bit_reg && speed_100);
    c_isolate: cover property (isolate ##1 !isolate);

endmodule

/* hw/phy_ctrl_pkg.sv */
package phy_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [4:0] CTRL_ADDR = 5'h00;
    localparam int RESET_BIT = 15;
    localparam int LOOPBACK_BIT = 14;
    localparam int SPEED_BIT = 13;
    localparam int AN_EN_BIT = 12;
    localparam int POWER_DOWN_BIT = 11;
    localparam int ISOLATE_BIT = 10;
    localparam int AN_RESTART_BIT = 9;
    localparam int DUPLEX_BIT = 8;
    localparam int COL_TEST_BIT = 7;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h3000;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SRST_TIME_NS = 1;
    localparam int SRST_TIME_PS = SRST_TIME_NS * 1000000;
    localparam int SRST_CYCLES = SRST_TIME_PS / CLK_PERIOD_PS;
    localparam logic [8:0] SRST_LAST = 9'(SRST_CYCLES - 1);
    localparam int COL_RISE_BITS = 512;
    localparam int COL_FALL_BITS = 4;
    localparam int BIT_TIME_FAST_PS = 10000;
    localparam int COL_FALL_PS = COL_FALL_BITS * BIT_TIME_FAST_PS;
    localparam int COL_FALL_CYCLES = COL_FALL_PS / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_s;

    typedef struct packed {
        logic autoneg_enable_pin;
        logic forced_speed_pin;
        logic full_duplex_pin;
        logic tx_en;
    } pins_s;

    typedef enum logic [1:0] {
        SRST_IDLE = 2'h1,
        SRST_BUSY = 2'h2
    } srst_state_e;

endpackage

/* hw/pin_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for the strap and data-interface pins
module pin_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire phy_ctrl_pkg::pins_s pins_in,
    output phy_ctrl_pkg::pins_s pins_out
);

    phy_ctrl_pkg::pins_s meta_reg;
    phy_ctrl_pkg::pins_s sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pins_in;
            sync_reg <= meta_reg;
        end
    end

    assign pins_out = sync_reg;

endmodule

/* tb/mgmt_model.sv */
`timescale 1ns/10ps
// Station manager and negotiator stand-in facing the register port
module mgmt_model (
    input wire logic clk,
    input wire logic an_restart,
    input wire logic [15:0] mgmt_rdata,
    output phy_ctrl_pkg::mgmt_req_s mgmt_req,
    output logic an_restart_ack
);
    int ack_delay = 1;
    logic [15:0] rd_val;

    // Idle bus at time zero
    initial begin
        mgmt_req = '0;
        an_restart_ack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write one word; reserved field always sent as zero
    task automatic wr(input logic [15:0] d);
        @(posedge clk);
        #1;
        mgmt_req.addr = phy_ctrl_pkg::CTRL_ADDR;
        mgmt_req.wdata = d & 16'hFF80;
        mgmt_req.wr = 1'b1;
        @(posedge clk);
        #1;
        mgmt_req.wr = 1'b0;
        mgmt_req.wdata = ~d; // Stale data must not look valid
    endtask

    // Read one word; data is taken the cycle after the request
    task automatic rd();
        @(posedge clk);
        #1;
        mgmt_req.addr = phy_ctrl_pkg::CTRL_ADDR;
        mgmt_req.rd = 1'b1;
        @(posedge clk);
        #1;
        rd_val = mgmt_rdata;
        mgmt_req.rd = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Negotiator accepts a restart after a prompt or slow delay
    always begin
        @(posedge clk);
        if (an_restart === 1'b1) begin
            repeat (ack_delay) @(posedge clk);
            #1 an_restart_ack = 1'b1;
            @(posedge clk);
            #1 an_restart_ack = 1'b0;
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the basic control register
module tb;
    logic clk = 1'b0;
    logic nrst;
    logic aux_restart;
    logic an_speed_100;
    logic an_full_duplex;
    phy_ctrl_pkg::pins_s pins;
    phy_ctrl_pkg::mgmt_req_s mgmt_req;
    logic an_restart_ack, soft_reset, loopback, isolate, speed_100;
    logic full_duplex, autoneg_active, an_restart, col, aux_speed;
    logic [5:0] em;
    logic [15:0] rdata;
    int errors = 0;
    int tests_run = 0;
    int pulses = 0;
    int ctrl_m;
    logic [31:0] seed = 32'h9134;

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Design, manager model and restart pulse counter
    phy_basic_control DUT (.clk(clk), .nrst(nrst), .mgmt_req(mgmt_req),
        .aux_restart(aux_restart), .pins(pins), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .an_restart_ack(an_restart_ack),
        .mgmt_rdata(rdata), .soft_reset(soft_reset), .loopback(loopback),
        .isolate(isolate), .speed_100(speed_100), .full_duplex(full_duplex),
        .autoneg_active(autoneg_active), .an_restart(an_restart),
        .aux_forced_speed(aux_speed), .col(col));
    mgmt_model mdl (.clk(clk), .an_restart(an_restart), .mgmt_rdata(rdata),
        .mgmt_req(mgmt_req), .an_restart_ack(an_restart_ack));
    always @(posedge clk) if (an_restart === 1'b1) pulses++;

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Expected mode outputs from the bench's own register copy
    function automatic logic [5:0] exp_mode(input int c);
        logic an, fs, sp, dx;
        an = pins.autoneg_enable_pin & c[12];
        fs = pins.autoneg_enable_pin ? c[13] : pins.forced_speed_pin;
        sp = an ? an_speed_100 : fs;
        dx = an ? an_full_duplex : (c[8] | pins.full_duplex_pin);
        return {c[14], c[10], sp, dx, an, fs};
    endfunction

    task automatic end_sim();
        $display("Counts: %0d compared, %0d mismatched", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0;
        aux_restart = 1'b0;
        an_speed_100 = 1'b0;
        an_full_duplex = 1'b0;
        pins = '0;
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        pins.autoneg_enable_pin = 1'b1;
        repeat (5) @(posedge clk);
        mdl.rd();
        check("reset value", mdl.rd_val, 16'h3000);
        mdl.wr(16'h3800);
        mdl.rd();
        check("read-only bit", mdl.rd_val, 16'h3000);
        $display("test reset value done");

        // Random settings against random pins and negotiated results
        repeat (40) begin
            seed = lfsr(seed);
            @(posedge clk);
            #1;
            pins = {seed[20:18], 1'b0};
            an_speed_100 = seed[17];
            an_full_duplex = seed[16];
            ctrl_m = int'(seed[15:0] & 16'h7580);
            mdl.wr(16'(ctrl_m));
            repeat (5) @(posedge clk);
            em = exp_mode(ctrl_m);
            check("loop", 16'(loopback), 16'(em[5]));
            check("isolate", 16'(isolate), 16'(em[4]));
            check("speed", 16'(speed_100), 16'(em[3]));
            check("duplex", 16'(full_duplex), 16'(em[2]));
            check("an", 16'(autoneg_active), 16'(em[1]));
            check("aux speed", 16'(aux_speed), 16'(em[0]));
            mdl.rd();
            check("readback", mdl.rd_val, 16'(ctrl_m));
            check("rb bits", mdl.rd_val, 16'(ctrl_m));
            check("rb srst", 16'(mdl.rd_val[15]), 16'h0000);
        end
        check("no restart", 16'(pulses), 16'h0000);
        $display("test random modes done");

        // Restart: two requests before the slow ack give one pulse
        @(posedge clk);
        #1 pins = 4'h8;
        mdl.ack_delay = 20;
        mdl.wr(16'h1000);
        repeat (5) @(posedge clk);
        pulses = 0;
        mdl.wr(16'h1200);
        mdl.wr(16'h1200);
        repeat (30) @(posedge clk);
        check("restart once", 16'(pulses), 16'h0001);
        pulses = 0;
        mdl.ack_delay = 1;
        @(posedge clk);
        #1 aux_restart = 1'b1;
        @(posedge clk);
        #1 aux_restart = 1'b0;
        repeat (10) @(posedge clk);
        check("aux restart", 16'(pulses), 16'h0001);
        mdl.rd();
        check("restart reads", mdl.rd_val, 16'h1000);
        // Disabled by software, then by the pin: no pulse either way
        pulses = 0;
        mdl.wr(16'h0000);
        mdl.wr(16'h0200);
        repeat (10) @(posedge clk);
        #1 pins = 4'h0;
        repeat (5) @(posedge clk);
        mdl.wr(16'h1200);
        repeat (10) @(posedge clk);
        check("restart refused", 16'(pulses), 16'h0000);
        $display("test restart done");

        // Software reset ignores other writes while busy
        mdl.wr(16'hC400);
        mdl.rd();
        check("reset busy", mdl.rd_val, 16'hB000);
        mdl.wr(16'h4000);
        check("reset flag", 16'(soft_reset), 16'h0001);
        repeat (260) @(posedge clk);
        mdl.rd();
        check("reset done", mdl.rd_val, 16'h3000);
        $display("test soft reset done");

        // Collision test inside loopback, then disabled
        mdl.wr(16'h4080);
        @(posedge clk);
        #1 pins.tx_en = 1'b1;
        repeat (6) @(posedge clk);
        check("col high", 16'(col), 16'h0001);
        #1 pins.tx_en = 1'b0;
        repeat (6) @(posedge clk);
        check("col low", 16'(col), 16'h0000);
        mdl.wr(16'h4000);
        @(posedge clk);
        #1 pins.tx_en = 1'b1;
        repeat (6) @(posedge clk);
        check("col off", 16'(col), 16'h0000);
        $display("test collision done");

        // Chip reset in mid-run clears loopback and restores defaults
        @(posedge clk);
        #1 nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        mdl.rd();
        check("chip reset", mdl.rd_val, 16'h3000);
        check("loopback off", 16'(loopback), 16'h0000);
        check("col reset", 16'(col), 16'h0000);
        $display("test chip reset done");
        end_sim();
    end
endmodule
